// [lsi_pkg.sv]
package lsi_pkg;

  // ---------------------------------------------------------------
  // Clock and indicator timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned SLOW_HALF_MS = 500;
  localparam int unsigned FAST_HALF_MS = 125;
  localparam int unsigned FLASH_MS = 30;
  localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * CYC_PER_MS;
  localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * CYC_PER_MS;
  localparam int unsigned FLASH_CYC = FLASH_MS * CYC_PER_MS;
  localparam int unsigned CHANNELS = 1;

  // ---------------------------------------------------------------
  // Register map, byte offsets on haddr[7:0]
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] OVR_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_RESTART_BIT = 1;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0003;
  localparam logic [31:0] CTRL_READ_MASK = 32'h0000_0001;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] OVR_MASK = 32'h0000_1f1f;
  localparam logic [31:0] OVR_RST = 32'h0000_0000;

  // Light patterns of one dual-colour LED
  typedef enum logic [2:0] {
    PAT_OFF, PAT_FLASH, PAT_SLOW, PAT_FAST, PAT_ON, PAT_SWAVER, PAT_FWAVER
  } lsi_pattern_t;

  // Script override word; sel picks the second colour for one-colour patterns
  typedef struct packed {
    logic [18:0] rsvd_hi;
    logic t_sel;
    logic [2:0] t_pat;
    logic t_en;
    logic [2:0] rsvd_lo;
    logic p_sel;
    logic [2:0] p_pat;
    logic p_en;
  } lsi_ovr_t;

  // Device-wide condition levels
  typedef struct packed {
    logic usb_configured;
    logic fw_cfg_error;
    logic low_power;
    logic fw_update;
    logic script_running;
  } lsi_status_t;

endpackage

// [lsi_led_status.sv]
`timescale 1ns/1ps
// How it works
// - Off pattern drives neither colour of the LED.
// - Flash lights the LED briefly per event; close events merge.
// - Slow blink toggles lit and dark with equal halves.
// - Fast blink toggles with equal halves, quicker than slow blink.
// - Steady on keeps the chosen colour lit continuously.
// - Slow waver swaps between both colours at slow blink timing.
// - Fast waver swaps between both colours at fast blink timing.
// - Running lights each colour alone: power green, yellow, traffic yellow, red.
// - Power LED green/yellow plus one yellow/red traffic LED per channel.
// - Device-wide errors drive all red traffic colours together in step.
// - Configured and healthy interface mode holds power LED steady green.
// - Before USB configuration, power slow-blinks yellow, traffic stays off.
// - Config error wavers both LEDs; low power wavers power, blinks traffic yellow.
// - Idle traffic off; yellow flash per message, red flash per error frame.
// - Firmware update fast-blinks all traffic LEDs yellow.
// - Error passive fast-blinks that channel's traffic LED red.
// - Overrun lights red steadily, latched until the channel goes bus-off.
// - No script indication by default; running script may override any LED.
module lsi_led_status #(
  parameter int unsigned CH = lsi_pkg::CHANNELS,
  parameter int unsigned SLOW_HALF = lsi_pkg::SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = lsi_pkg::FAST_HALF_CYC,
  parameter int unsigned FLASH_LEN = lsi_pkg::FLASH_CYC
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  input wire lsi_pkg::lsi_status_t status, // Device-wide levels
  input wire logic [CH-1:0] can_msg, // Message sent or received pulse
  input wire logic [CH-1:0] can_err_frame, // Error frame received pulse
  input wire logic [CH-1:0] can_err_passive, // Error passive level
  input wire logic [CH-1:0] can_overrun, // Receive overrun pulse
  input wire logic [CH-1:0] can_bus_off, // Bus-off level
  output logic power_indicator_green, // Power LED green
  output logic power_indicator_yellow, // Power LED yellow
  output logic [CH-1:0] traffic_yellow, // Traffic LED yellow
  output logic [CH-1:0] traffic_red // Traffic LED red
);

  localparam int unsigned RUN_LEN = 2 + 2 * CH;
  localparam int unsigned RUN_W = $clog2(RUN_LEN);

  // ---------------------------------------------------------------
  // Pattern decode
  // ---------------------------------------------------------------
  // Returns {second, first} colour drive for one dual-colour LED
  function automatic logic [1:0] pat_drive(input lsi_pkg::lsi_pattern_t pat, input logic sel,
                                           input logic slow, input logic fast, input logic flash);
    logic on;
    logic [1:0] res;
    on = 1'b0;
    res = 2'b00;
    unique case (pat)
      lsi_pkg::PAT_OFF: on = 1'b0;
      lsi_pkg::PAT_FLASH: on = flash;
      lsi_pkg::PAT_SLOW: on = slow;
      lsi_pkg::PAT_FAST: on = fast;
      lsi_pkg::PAT_ON: on = 1'b1;
      lsi_pkg::PAT_SWAVER: res = slow ? 2'b01 : 2'b10;
      lsi_pkg::PAT_FWAVER: res = fast ? 2'b01 : 2'b10;
      default: on = 1'b0;
    endcase
    if (on) begin
      res = sel ? 2'b10 : 2'b01;
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // Bus slave state
  // ---------------------------------------------------------------
  logic dp_wr_reg, dp_wr_next;
  logic [7:0] addr_reg, addr_next;
  logic [31:0] ctrl_reg, ctrl_next;
  lsi_pkg::lsi_ovr_t ovr_reg, ovr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic [31:0] stat_word;
  logic addr_phase;

  // Timing and channel state
  logic [31:0] slow_cnt_reg, slow_cnt_next;
  logic [31:0] fast_cnt_reg, fast_cnt_next;
  logic slow_ph_reg, slow_ph_next;
  logic fast_ph_reg, fast_ph_next;
  logic slow_wrap;
  logic [RUN_W-1:0] run_idx_reg, run_idx_next;
  logic [CH-1:0][31:0] yfl_cnt_reg, yfl_cnt_next;
  logic [CH-1:0][31:0] rfl_cnt_reg, rfl_cnt_next;
  logic [CH-1:0] ovr_lat_reg, ovr_lat_next;

  // Indicator outputs
  logic [1:0] pled_reg, pled_next;
  logic [CH-1:0][1:0] trf_reg, trf_next;

  // ---------------------------------------------------------------
  // AHB-Lite register access
  // ---------------------------------------------------------------
  // Zero wait states; reads use the post-write values so a read right after a write sees it
  always_comb begin
    addr_phase = hsel && htrans[1] && hready;
    dp_wr_next = addr_phase && hwrite;
    addr_next = addr_phase ? haddr[7:0] : addr_reg;
    ctrl_next = ctrl_reg;
    ctrl_next[lsi_pkg::CTRL_RESTART_BIT] = 1'b0;
    ovr_next = ovr_reg;
    if (dp_wr_reg && addr_reg == lsi_pkg::CTRL_OFS) begin
      ctrl_next = hwdata & lsi_pkg::CTRL_MASK;
    end
    if (dp_wr_reg && addr_reg == lsi_pkg::OVR_OFS) begin
      ovr_next = hwdata & lsi_pkg::OVR_MASK;
    end
    stat_word = 32'h0000_0000;
    stat_word[1:0] = pled_reg;
    for (int c = 0; c < CH; c++) begin
      stat_word[2 + 2 * c +: 2] = trf_reg[c];
      stat_word[16 + c] = ovr_lat_reg[c];
    end
    hrdata_next = hrdata_reg;
    if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        lsi_pkg::CTRL_OFS: hrdata_next = ctrl_next & lsi_pkg::CTRL_READ_MASK;
        lsi_pkg::OVR_OFS: hrdata_next = ovr_next;
        lsi_pkg::STAT_OFS: hrdata_next = stat_word;
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg <= 1'b0;
      addr_reg <= 8'h00;
      ctrl_reg <= lsi_pkg::CTRL_RST;
      ovr_reg <= lsi_pkg::OVR_RST;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      dp_wr_reg <= dp_wr_next;
      addr_reg <= addr_next;
      ctrl_reg <= ctrl_next;
      ovr_reg <= ovr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // ---------------------------------------------------------------
  // Blink timebases and channel memory
  // ---------------------------------------------------------------
  // Both phases share one start so all LEDs in a pattern stay in step
  always_comb begin
    slow_wrap = slow_cnt_reg >= SLOW_HALF - 1;
    slow_cnt_next = slow_wrap ? 32'h0000_0000 : slow_cnt_reg + 32'h0000_0001;
    slow_ph_next = slow_wrap ? !slow_ph_reg : slow_ph_reg;
    fast_cnt_next = (fast_cnt_reg >= FAST_HALF - 1) ? 32'h0000_0000 : fast_cnt_reg + 32'h0000_0001;
    fast_ph_next = (fast_cnt_reg >= FAST_HALF - 1) ? !fast_ph_reg : fast_ph_reg;
    run_idx_next = run_idx_reg;
    if (slow_wrap) begin
      run_idx_next = (32'(run_idx_reg) == RUN_LEN - 1) ? '0 : run_idx_reg + RUN_W'(1);
    end
    if (ctrl_reg[lsi_pkg::CTRL_RESTART_BIT]) begin
      slow_cnt_next = 32'h0000_0000;
      fast_cnt_next = 32'h0000_0000;
      slow_ph_next = 1'b0;
      fast_ph_next = 1'b0;
      run_idx_next = '0;
    end
    for (int c = 0; c < CH; c++) begin
      // A new event reloads the stretch, so a burst merges into steady light
      yfl_cnt_next[c] = can_msg[c] ? FLASH_LEN : yfl_cnt_reg[c] - 32'(yfl_cnt_reg[c] != 0);
      rfl_cnt_next[c] = can_err_frame[c] ? FLASH_LEN : rfl_cnt_reg[c] - 32'(rfl_cnt_reg[c] != 0);
      // Set wins over bus-off release in the same cycle
      ovr_lat_next[c] = can_overrun[c] ? 1'b1 : (can_bus_off[c] ? 1'b0 : ovr_lat_reg[c]);
    end
  end

  // Timebase registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_cnt_reg <= 32'h0000_0000;
      fast_cnt_reg <= 32'h0000_0000;
      slow_ph_reg <= 1'b0;
      fast_ph_reg <= 1'b0;
      run_idx_reg <= '0;
      yfl_cnt_reg <= '0;
      rfl_cnt_reg <= '0;
      ovr_lat_reg <= '0;
    end else begin
      slow_cnt_reg <= slow_cnt_next;
      fast_cnt_reg <= fast_cnt_next;
      slow_ph_reg <= slow_ph_next;
      fast_ph_reg <= fast_ph_next;
      run_idx_reg <= run_idx_next;
      yfl_cnt_reg <= yfl_cnt_next;
      rfl_cnt_reg <= rfl_cnt_next;
      ovr_lat_reg <= ovr_lat_next;
    end
  end

  // ---------------------------------------------------------------
  // Indicator selection
  // ---------------------------------------------------------------
  // Priority: running test, script override, then device conditions
  logic pled_ovr, trf_ovr, run_on;
  always_comb begin
    run_on = ctrl_reg[lsi_pkg::CTRL_RUN_BIT];
    pled_ovr = status.script_running && ovr_reg.p_en;
    trf_ovr = status.script_running && ovr_reg.t_en;
    if (status.fw_cfg_error || status.low_power) begin
      pled_next = pat_drive(lsi_pkg::PAT_SWAVER, 1'b0, slow_ph_reg, fast_ph_reg, 1'b0);
    end else if (!status.usb_configured) begin
      pled_next = pat_drive(lsi_pkg::PAT_SLOW, 1'b1, slow_ph_reg, fast_ph_reg, 1'b0);
    end else begin
      pled_next = pat_drive(lsi_pkg::PAT_ON, 1'b0, slow_ph_reg, fast_ph_reg, 1'b0);
    end
    if (pled_ovr) begin
      pled_next = pat_drive(lsi_pkg::lsi_pattern_t'(ovr_reg.p_pat), ovr_reg.p_sel, slow_ph_reg,
                            fast_ph_reg, slow_ph_reg);
    end
    if (run_on) begin
      pled_next = {run_idx_reg == RUN_W'(1), run_idx_reg == RUN_W'(0)};
    end
    for (int c = 0; c < CH; c++) begin
      // Each channel uses the shared phases, keeping all reds in step
      if (!status.usb_configured) begin
        trf_next[c] = 2'b00;
      end else if (status.fw_cfg_error) begin
        trf_next[c] = pat_drive(lsi_pkg::PAT_SWAVER, 1'b0, slow_ph_reg, fast_ph_reg, 1'b0);
      end else if (status.low_power) begin
        trf_next[c] = pat_drive(lsi_pkg::PAT_SLOW, 1'b0, slow_ph_reg, fast_ph_reg, 1'b0);
      end else if (status.fw_update) begin
        trf_next[c] = pat_drive(lsi_pkg::PAT_FAST, 1'b0, slow_ph_reg, fast_ph_reg, 1'b0);
      end else if (ovr_lat_reg[c]) begin
        trf_next[c] = pat_drive(lsi_pkg::PAT_ON, 1'b1, slow_ph_reg, fast_ph_reg, 1'b0);
      end else if (can_err_passive[c]) begin
        trf_next[c] = pat_drive(lsi_pkg::PAT_FAST, 1'b1, slow_ph_reg, fast_ph_reg, 1'b0);
      end else begin
        trf_next[c] = {rfl_cnt_reg[c] != 0, yfl_cnt_reg[c] != 0};
      end
      if (trf_ovr) begin
        trf_next[c] = pat_drive(lsi_pkg::lsi_pattern_t'(ovr_reg.t_pat), ovr_reg.t_sel, slow_ph_reg,
                                fast_ph_reg, yfl_cnt_reg[c] != 0);
      end
      if (run_on) begin
        trf_next[c] = {32'(run_idx_reg) == 3 + 2 * c, 32'(run_idx_reg) == 2 + 2 * c};
      end
    end
  end

  // Indicator registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pled_reg <= 2'b00;
      trf_reg <= '0;
    end else begin
      pled_reg <= pled_next;
      trf_reg <= trf_next;
    end
  end

  // One colour pair per LED
  assign power_indicator_green = pled_reg[0];
  assign power_indicator_yellow = pled_reg[1];
  always_comb begin
    for (int c = 0; c < CH; c++) begin
      traffic_yellow[c] = trf_reg[c][0];
      traffic_red[c] = trf_reg[c][1];
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic quiet;
  assign quiet = !run_on && !pled_ovr && !trf_ovr;

  property p_unconfigured;
    @(posedge hclk) disable iff (!hresetn)
      (!status.usb_configured && !status.fw_cfg_error && !status.low_power && quiet)
        |=> (traffic_yellow == '0 && traffic_red == '0 && !power_indicator_green
             && power_indicator_yellow == $past(slow_ph_reg));
  endproperty
  a_unconfigured: assert property (p_unconfigured) else $error("unconfigured pattern wrong");

  property p_healthy_green;
    @(posedge hclk) disable iff (!hresetn)
      (status.usb_configured && !status.fw_cfg_error && !status.low_power && quiet)
        |=> (power_indicator_green && !power_indicator_yellow);
  endproperty
  a_healthy_green: assert property (p_healthy_green) else $error("power not steady green");

  property p_waver;
    @(posedge hclk) disable iff (!hresetn)
      (status.fw_cfg_error && quiet) |=> (power_indicator_green == $past(slow_ph_reg)
                                          && power_indicator_yellow == !$past(slow_ph_reg));
  endproperty
  a_waver: assert property (p_waver) else $error("slow waver wrong");

  property p_red_together;
    @(posedge hclk) disable iff (!hresetn)
      (status.usb_configured && status.fw_cfg_error && quiet) |=> (traffic_red == {CH{!$past(slow_ph_reg)}});
  endproperty
  a_red_together: assert property (p_red_together) else $error("reds not in step");

  property p_slow_half;
    @(posedge hclk) disable iff (!hresetn)
      (slow_ph_reg != $past(slow_ph_reg) && !$past(ctrl_reg[lsi_pkg::CTRL_RESTART_BIT]))
        |-> ($past(slow_cnt_reg) == SLOW_HALF - 1);
  endproperty
  a_slow_half: assert property (p_slow_half) else $error("slow phase toggled early");

  property p_overrun_hold;
    @(posedge hclk) disable iff (!hresetn)
      (can_overrun[0] ##1 (!can_bus_off[0])[*2]) |-> ovr_lat_reg[0];
  endproperty
  a_overrun_hold: assert property (p_overrun_hold) else $error("overrun latch lost");

  property p_flash_load;
    @(posedge hclk) disable iff (!hresetn)
      can_msg[0] |=> (yfl_cnt_reg[0] == FLASH_LEN) ##1 ($past(can_msg[0]) || yfl_cnt_reg[0] == FLASH_LEN - 1);
  endproperty
  a_flash_load: assert property (p_flash_load) else $error("flash stretch wrong");

  property p_idle_flash;
    @(posedge hclk) disable iff (!hresetn)
      (status == 5'b10000 && !ovr_lat_reg[0] && !can_err_passive[0] && !run_on)
        |=> (traffic_yellow[0] == ($past(yfl_cnt_reg[0]) != 0) && traffic_red[0] == ($past(rfl_cnt_reg[0]) != 0));
  endproperty
  a_idle_flash: assert property (p_idle_flash) else $error("traffic flash wrong");

  property p_passive_fast;
    @(posedge hclk) disable iff (!hresetn)
      (status == 5'b10000 && !ovr_lat_reg[0] && can_err_passive[0] && !run_on)
        |=> (traffic_red[0] == $past(fast_ph_reg) && !traffic_yellow[0]);
  endproperty
  a_passive_fast: assert property (p_passive_fast) else $error("error passive blink wrong");

  property p_running_onehot;
    @(posedge hclk) disable iff (!hresetn)
      run_on |=> $onehot({traffic_red, traffic_yellow, power_indicator_yellow, power_indicator_green});
  endproperty
  a_running_onehot: assert property (p_running_onehot) else $error("running not one at a time");

  property p_fast_half;
    @(posedge hclk) disable iff (!hresetn)
      (fast_ph_reg != $past(fast_ph_reg) && !$past(ctrl_reg[lsi_pkg::CTRL_RESTART_BIT]))
        |-> ($past(fast_cnt_reg) == FAST_HALF - 1);
  endproperty
  a_fast_half: assert property (p_fast_half) else $error("fast phase toggled early");

  property p_low_power;
    @(posedge hclk) disable iff (!hresetn)
      (status.usb_configured && !status.fw_cfg_error && status.low_power && quiet)
        |=> (traffic_yellow == {CH{$past(slow_ph_reg)}} && traffic_red == '0
             && power_indicator_green == $past(slow_ph_reg));
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power pattern wrong");

  property p_fw_update;
    @(posedge hclk) disable iff (!hresetn)
      (status.usb_configured && !status.fw_cfg_error && !status.low_power && status.fw_update && quiet)
        |=> (traffic_yellow == {CH{$past(fast_ph_reg)}} && traffic_red == '0);
  endproperty
  a_fw_update: assert property (p_fw_update) else $error("update blink wrong");

  property p_overrun_red;
    @(posedge hclk) disable iff (!hresetn)
      (status == 5'b10000 && ovr_lat_reg[0] && !run_on) |=> (traffic_red[0] && !traffic_yellow[0]);
  endproperty
  a_overrun_red: assert property (p_overrun_red) else $error("overrun not steady red");

endmodule

// [lsi_led_eye.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Dual-colour LED as an observer sees it
// ---------------------------------------------------------------
module lsi_led_eye (
  input wire logic hclk, // Clock
  input wire logic clr, // Clear the statistics
  input wire logic [1:0] lit, // Colour drives, high = lit
  output logic [1:0][31:0] hi_len, // Last lit run per colour
  output logic [1:0][31:0] lo_len, // Last dark run per colour
  output logic [1:0][31:0] on_cnt, // Lit cycles since clear
  output logic both // Both colours seen lit together
);
  logic [1:0] prev;
  logic [1:0][31:0] run;

  // Run lengths per colour; the first run after a clear is partial
  always_ff @(posedge hclk) begin
    if (clr) begin
      prev <= lit;
      run <= '0;
      hi_len <= '0;
      lo_len <= '0;
      on_cnt <= '0;
      both <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (lit[i] !== prev[i]) begin
          if (prev[i]) begin
            hi_len[i] <= run[i];
          end else begin
            lo_len[i] <= run[i];
          end
          run[i] <= 32'h0000_0001;
        end else begin
          run[i] <= run[i] + 32'h0000_0001;
        end
        if (lit[i]) begin
          on_cnt[i] <= on_cnt[i] + 32'h0000_0001;
        end
      end
      prev <= lit;
      if (lit === 2'b11) begin
        both <= 1'b1;
      end
    end
  end
endmodule

// [lsi_led_status_tb_top.sv]
`timescale 1ns/1ps
module lsi_led_status_tb_top;
  localparam int unsigned SLOW = 8;
  localparam int unsigned FAST = 3;
  localparam int unsigned FLASH = 4;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, clr;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  lsi_pkg::lsi_status_t st;
  logic [0:0] can_msg, can_err_frame, can_err_passive, can_overrun, can_bus_off, ty, tr;
  logic pg, py, p_both, t_both;
  logic [1:0][31:0] p_hi, p_lo, p_on, t_hi, t_lo, t_on;
  int fails, num_checks;

  // ---------------------------------------------------------------
  // Design, observers and clock
  // ---------------------------------------------------------------
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  lsi_led_status #(.CH(1), .SLOW_HALF(SLOW), .FAST_HALF(FAST), .FLASH_LEN(FLASH)) lsi_led_status_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .status(st), .can_msg(can_msg), .can_err_frame(can_err_frame), .can_err_passive(can_err_passive),
    .can_overrun(can_overrun), .can_bus_off(can_bus_off), .power_indicator_green(pg),
    .power_indicator_yellow(py), .traffic_yellow(ty), .traffic_red(tr));
  lsi_led_eye lsi_led_eye_inst_p (.hclk(hclk), .clr(clr), .lit({py, pg}), .hi_len(p_hi), .lo_len(p_lo),
    .on_cnt(p_on), .both(p_both));
  lsi_led_eye lsi_led_eye_inst_t (.hclk(hclk), .clr(clr), .lit({tr, ty}), .hi_len(t_hi), .lo_len(t_lo),
    .on_cnt(t_on), .both(t_both));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Equal lit and dark halves of one colour
  task automatic runs(input logic [31:0] hi, input logic [31:0] lo, input int unsigned e);
    check(hi, 32'(e));
    check(lo, 32'(e));
  endtask

  // Single AHB-Lite word transfer, held until hready is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  // Let the pattern settle, clear the observers, then watch n cycles
  task automatic watch(input int n);
    repeat (3) @(posedge hclk);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask

  task automatic settle();
    repeat (20) @(posedge hclk);
    @(negedge hclk);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_regs();
    logic [31:0] r;
    check({28'h0, pg, py, ty, tr}, 32'h0);
    check({31'h0, hresp}, 32'h0);
    bus(1'b0, lsi_pkg::CTRL_OFS, 32'h0, r);
    check(r, lsi_pkg::CTRL_RST);
    bus(1'b0, lsi_pkg::OVR_OFS, 32'h0, r);
    check(r, lsi_pkg::OVR_RST);
    bus(1'b1, lsi_pkg::OVR_OFS, 32'hffff_ffff, r);
    bus(1'b0, lsi_pkg::OVR_OFS, 32'h0, r);
    check(r, lsi_pkg::OVR_MASK);
    bus(1'b1, lsi_pkg::CTRL_OFS, 32'h0000_0002, r);
    bus(1'b0, lsi_pkg::CTRL_OFS, 32'h0, r);
    check(r, 32'h0);
    bus(1'b1, 8'h0c, 32'hffff_ffff, r);
    bus(1'b0, 8'h0c, 32'h0, r);
    check(r, 32'h0);
    bus(1'b1, lsi_pkg::OVR_OFS, 32'h0, r);
    $display("test regs done");
  endtask

  task automatic test_unconfigured();
    watch(48);
    runs(p_hi[1], p_lo[1], SLOW);
    check(p_on[0], 32'h0);
    check(t_on[0] | t_on[1], 32'h0);
    $display("test unconfigured done");
  endtask

  task automatic test_flash();
    @(posedge hclk);
    st.usb_configured <= 1'b1;
    watch(40);
    check(p_on[0], 32'd40);
    check(p_on[1] | t_on[0] | t_on[1], 32'h0);
    @(posedge hclk);
    can_msg <= 1'b1;
    @(posedge hclk);
    can_msg <= 1'b0;
    settle();
    check(t_on[0], 32'(FLASH));
    watch(2);
    @(posedge hclk);
    can_msg <= 1'b1;
    @(posedge hclk);
    can_msg <= 1'b0;
    @(posedge hclk);
    can_msg <= 1'b1;
    @(posedge hclk);
    can_msg <= 1'b0;
    settle();
    check(t_hi[0], 32'(FLASH + 2));
    watch(2);
    @(posedge hclk);
    can_err_frame <= 1'b1;
    @(posedge hclk);
    can_err_frame <= 1'b0;
    settle();
    check(t_on[1], 32'(FLASH));
    check(t_on[0], 32'h0);
    $display("test flash done");
  endtask

  task automatic test_errors();
    logic [31:0] r;
    @(posedge hclk);
    can_err_passive <= 1'b1;
    watch(30);
    runs(t_hi[1], t_lo[1], FAST);
    @(posedge hclk);
    can_msg <= 1'b1;
    @(posedge hclk);
    can_msg <= 1'b0;
    settle();
    check(t_on[0], 32'h0);
    @(posedge hclk);
    can_err_passive <= 1'b0;
    st.fw_update <= 1'b1;
    watch(30);
    runs(t_hi[0], t_lo[0], FAST);
    check(t_on[1], 32'h0);
    @(posedge hclk);
    st.fw_update <= 1'b0;
    can_overrun <= 1'b1;
    @(posedge hclk);
    can_overrun <= 1'b0;
    watch(40);
    check(t_on[1], 32'd40);
    bus(1'b0, lsi_pkg::STAT_OFS, 32'h0, r);
    check(r & 32'h0001_000f, 32'h0001_0009);
    @(posedge hclk);
    can_bus_off <= 1'b1;
    @(posedge hclk);
    can_bus_off <= 1'b0;
    watch(20);
    check(t_on[1], 32'h0);
    $display("test errors done");
  endtask

  task automatic test_cfg_power();
    @(posedge hclk);
    st.fw_cfg_error <= 1'b1;
    watch(64);
    runs(p_hi[0], p_lo[0], SLOW);
    runs(p_hi[1], p_lo[1], SLOW);
    runs(t_hi[0], t_lo[0], SLOW);
    runs(t_hi[1], t_lo[1], SLOW);
    check({31'h0, p_both | t_both}, 32'h0);
    @(posedge hclk);
    st.fw_cfg_error <= 1'b0;
    st.low_power <= 1'b1;
    watch(64);
    runs(p_hi[0], p_lo[0], SLOW);
    runs(t_hi[0], t_lo[0], SLOW);
    check(t_on[1], 32'h0);
    @(posedge hclk);
    st.low_power <= 1'b0;
    $display("test config and power done");
  endtask

  task automatic test_running();
    logic [31:0] r;
    int n;
    bus(1'b1, lsi_pkg::CTRL_OFS, 32'h0000_0001, r);
    n = 0;
    while (pg === 1'b1 && n < 100) begin
      @(negedge hclk);
      n++;
    end
    while (pg !== 1'b1 && n < 100) begin
      @(negedge hclk);
      n++;
    end
    check(32'(n < 100), 32'h1);
    repeat (SLOW / 2) @(negedge hclk);
    for (int i = 0; i < 8; i++) begin
      check({28'h0, pg, py, ty, tr}, 32'h8 >> (i % 4));
      repeat (SLOW) @(negedge hclk);
    end
    bus(1'b1, lsi_pkg::CTRL_OFS, 32'h0, r);
    $display("test running done");
  endtask

  // Override words: power fields in [4:0], traffic fields in [12:8]
  task automatic test_override();
    logic [31:0] r;
    bus(1'b1, lsi_pkg::OVR_OFS, 32'h0000_1901, r);
    watch(30);
    check(p_on[0], 32'd30);
    @(posedge hclk);
    st.script_running <= 1'b1;
    watch(48);
    check(p_on[0] | p_on[1] | t_on[0], 32'h0);
    check(t_on[1], 32'd48);
    bus(1'b1, lsi_pkg::OVR_OFS, 32'h0000_0d07, r);
    watch(48);
    runs(p_hi[0], p_lo[0], FAST);
    runs(t_hi[0], t_lo[0], FAST);
    runs(t_hi[1], t_lo[1], FAST);
    check({31'h0, t_both}, 32'h0);
    bus(1'b1, lsi_pkg::OVR_OFS, 32'h0000_010b, r);
    watch(64);
    runs(p_hi[0], p_lo[0], SLOW);
    runs(p_hi[1], p_lo[1], SLOW);
    check(t_on[0] | t_on[1], 32'h0);
    // Traffic flash in red; power on the unused code must stay dark
    bus(1'b1, lsi_pkg::OVR_OFS, 32'h0000_131f, r);
    watch(2);
    @(posedge hclk);
    can_msg <= 1'b1;
    @(posedge hclk);
    can_msg <= 1'b0;
    settle();
    check(t_on[1], 32'(FLASH));
    check(t_on[0] | p_on[0] | p_on[1], 32'h0);
    bus(1'b1, lsi_pkg::OVR_OFS, 32'h0, r);
    @(posedge hclk);
    st.script_running <= 1'b0;
    $display("test override done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {hsel, hwrite, clr} = 3'b000;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    st = '0;
    {can_msg, can_err_frame, can_err_passive, can_overrun, can_bus_off} = 5'b00000;
    repeat (20) @(posedge hclk);
    @(negedge hclk);
    check(hrdata, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    test_regs();
    test_unconfigured();
    test_flash();
    test_errors();
    test_cfg_power();
    test_running();
    test_override();
    final_report();
  end

  // Whole run is near 900 cycles; cut a hang well beyond that
  initial begin
    #200_000;
    fails++;
    final_report();
  end
endmodule
